// file: hw/ras_consts.svh
/*
 * Constants of the remote alias, status and pin-zero register slice: offsets,
 * field positions, reset values and widths.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef RAS_CONSTS_SVH
`define RAS_CONSTS_SVH

// ==========================================================================
// Register offsets
`define RAS_OFF_TARGET_REAL   8'h07
`define RAS_OFF_TARGET_ALIAS  8'h08
`define RAS_OFF_CRC_LOW       8'h0A
`define RAS_OFF_CRC_HIGH      8'h0B
`define RAS_OFF_HEALTH        8'h0C
`define RAS_OFF_PIN_ZERO      8'h0D

// ==========================================================================
// Field positions
`define RAS_ADDR_MSB          7
`define RAS_ADDR_LSB          1
`define RAS_HLT_SELFTEST      3
`define RAS_HLT_PCLK          2
`define RAS_HLT_DES_ERR       1
`define RAS_HLT_LINK          0
`define RAS_PZ_LEVEL          3
`define RAS_PZ_MODE_MSB       2
`define RAS_PZ_REV_LSB        4

// ==========================================================================
// Reset values and widths
`define RAS_RST_ADDR          7'h00
`define RAS_RST_COUNT         16'h0000
`define RAS_RST_LEVEL         1'b0
`define RAS_RST_MODE          3'h0
`define RAS_RST_RDATA         8'h00
`define RAS_COUNT_MAX         16'hFFFF
`define RAS_PORTS             2

`endif

// file: hw/ras_pin_zero.sv
/*
 * Drive logic of one pin zero: decodes the mode field and chooses between the
 * local level, the remote level and the held value.
 * Assumes the remote level is only meaningful while link_up_in is high.
 */
`timescale 1ns/1ns
`include "ras_consts.svh"

module ras_pin_zero (
  // Clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               sys_rst_in,
  // Configuration
  input  wire logic [2:0]         mode_in,
  input  wire logic               local_level_in,
  // Remote side
  input  wire logic               remote_level_in,
  input  wire logic               link_up_in,
  // Pin
  output ras_pkg::ras_pin_drive_t drive_out
);

  ras_pkg::ras_pin_drive_t drive_d;
  ras_pkg::ras_pin_drive_t drive_q;

  // ========================================================================
  // Mode decode
  always_comb begin
    drive_d          = '0;
    drive_d.level    = drive_q.level;
    case (mode_in)
      3'h0, 3'h4: begin
        drive_d.func_sel = 1'b1;
      end
      3'h2, 3'h6: begin
        drive_d.oe = 1'b0;
      end
      3'h1: begin
        drive_d.oe    = 1'b1;
        drive_d.level = local_level_in;
      end
      3'h3: begin
        drive_d.oe = 1'b0;
      end
      3'h5: begin
        drive_d.oe = 1'b1;
        // Without link the last driven value is held.
        if (link_up_in) begin
          drive_d.level = remote_level_in;
        end
      end
      3'h7: begin
        drive_d.oe    = 1'b1;
        drive_d.level = link_up_in ? remote_level_in : local_level_in;
      end
      default: begin
        drive_d.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  assign drive_out = drive_q;

endmodule

// file: hw/ras_pkg.sv
/*
 * Types shared by the register slice and its pin-zero driver.
 * Assumes ras_consts.svh for widths.
 */
`include "ras_consts.svh"

package ras_pkg;

  // ========================================================================
  // Register port request from the serial control bus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ras_reg_req_t;

  // ========================================================================
  // Forwarded transaction address lookup
  typedef struct packed {
    logic       valid;
    logic       port;
    logic [6:0] addr;
  } ras_fwd_req_t;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [6:0] addr;
  } ras_fwd_ans_t;

  // ========================================================================
  // Pin-zero drive
  typedef struct packed {
    logic level;
    logic oe;
    logic func_sel;
  } ras_pin_drive_t;

endpackage

// file: hw/ras_regs.sv
/*
 * Remote alias, CRC error count, link health and pin-zero register slice,
 * banked for two serial ports.
 * Assumes a serial control bus engine that presents byte reads and writes on
 * the register port, and link logic that reports events synchronous to the
 * reference clock.
 * The two count bytes are read one at a time and are not latched together, so
 * software that reads while errors arrive can see a torn 16-bit value.
 * The lookup port names its own link, so forwarding does not depend on which
 * bank the register port happens to select.
 */
`timescale 1ns/1ns
`include "ras_consts.svh"

module ras_regs #(
  parameter int         PORTS        = `RAS_PORTS,
  // Value is arbitrary and names no real part.
  parameter logic [3:0] SILICON_REV  = 4'h1
) (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  // Register port
  input  wire ras_pkg::ras_reg_req_t  reg_req_in,
  output ras_pkg::ras_reg_req_t       reg_unused_out,
  output logic [7:0]                  reg_rdata_out,
  // Controls held in other registers
  input  wire logic                   second_port_select_in,
  input  wire logic                   crc_error_reset_in,
  // Per-port link events
  input  wire logic [PORTS-1:0]       link_detect_in,
  input  wire logic [PORTS-1:0]       backchannel_crc_err_in,
  input  wire logic [PORTS-1:0]       selftest_active_in,
  input  wire logic [PORTS-1:0]       selftest_restart_in,
  input  wire logic [PORTS-1:0]       remote_level_in,
  // Pixel clock monitor
  input  wire logic                   pclk_valid_in,
  input  wire logic                   pclk_out_of_range_in,
  // Forwarded transaction lookup
  input  wire ras_pkg::ras_fwd_req_t  fwd_req_in,
  output ras_pkg::ras_fwd_ans_t       fwd_ans_out,
  // Pin zero and second_port_pin_zero
  output ras_pkg::ras_pin_drive_t [PORTS-1:0] pin_zero_out
);

  // ========================================================================
  // Storage
  // Per-port address pair used by both the register port and the lookup.
  logic [6:0]  target_real_address_q  [PORTS];
  logic [6:0]  target_alias_address_q [PORTS];
  // Per-port error record; the count saturates rather than wrapping.
  logic [15:0] crc_count_q            [PORTS];
  logic        selftest_checksum_error_q [PORTS];
  logic        des_error_q            [PORTS];
  // Per-port pin-zero setup.
  logic        pin_zero_local_level_q [PORTS];
  logic [2:0]  pin_zero_mode_q        [PORTS];
  // Shared state: the pixel input exists once, not per link.
  logic        pclk_detect_q;
  // Register port and lookup pipeline.
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  ras_pkg::ras_fwd_ans_t fwd_ans_q;
  ras_pkg::ras_fwd_ans_t fwd_ans_d;
  ras_pkg::ras_reg_req_t unused_q;
  logic        sel;

  assign sel = second_port_select_in;

  // True when a write strikes the given offset.
  function automatic logic hit_wr(input ras_pkg::ras_reg_req_t req, input logic [7:0] off);
    hit_wr = req.wr && (req.addr == off);
  endfunction

  // True when the target entry is usable: both addresses non-zero.
  // Used by the lookup; a zero in either field disables the target.
  function automatic logic entry_live(input logic [6:0] real_a, input logic [6:0] alias_a);
    entry_live = (real_a != `RAS_RST_ADDR) && (alias_a != `RAS_RST_ADDR);
  endfunction

  // ========================================================================
  // Per-port state
  // Every port keeps its own copy of each banked field. Writes reach only the
  // bank that the select names; the error logic of every port runs always.
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic bank;
    assign bank = (sel == 1'(p));

    // Address registers. Bit 0 of each byte is reserved and is dropped on
    // write, so a read always returns it as zero.
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        target_real_address_q[p]  <= `RAS_RST_ADDR;
        target_alias_address_q[p] <= `RAS_RST_ADDR;
      end else begin
        if (bank && hit_wr(reg_req_in, `RAS_OFF_TARGET_REAL)) begin
          target_real_address_q[p] <=
            reg_req_in.wdata[`RAS_ADDR_MSB:`RAS_ADDR_LSB];
        end
        if (bank && hit_wr(reg_req_in, `RAS_OFF_TARGET_ALIAS)) begin
          target_alias_address_q[p] <=
            reg_req_in.wdata[`RAS_ADDR_MSB:`RAS_ADDR_LSB];
        end
      end
    end

    // Back-channel CRC error count. The reset control is a level, so the
    // count sits at zero for as long as software leaves it set. An error that
    // lands in a cycle with the control set is lost on purpose: the count
    // restarts only from errors seen after software writes the control back.
    // Saturation keeps a long error burst from reading as a small number.
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        crc_count_q[p] <= `RAS_RST_COUNT;
      end else if (crc_error_reset_in) begin
        crc_count_q[p] <= `RAS_RST_COUNT;
      end else if (backchannel_crc_err_in[p] && crc_count_q[p] != `RAS_COUNT_MAX) begin
        crc_count_q[p] <= crc_count_q[p] + 16'h0001;
      end
    end

    // Error flags. Clearing conditions are levels that outrank new errors.
    // A self-test restart that meets an error in one cycle leaves the flag
    // clear, so the flag only reports errors of the run now in progress.
    // The running self-test decides which of the two flags an error sets.
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        selftest_checksum_error_q[p] <= 1'b0;
      end else if (!link_detect_in[p] || selftest_restart_in[p] || crc_error_reset_in) begin
        selftest_checksum_error_q[p] <= 1'b0;
      end else if (backchannel_crc_err_in[p] && selftest_active_in[p]) begin
        selftest_checksum_error_q[p] <= 1'b1;
      end
    end

    // Normal-traffic error flag: only a link loss or the reset control clear
    // it, so one stray error stays visible until software looks.
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        des_error_q[p] <= 1'b0;
      end else if (!link_detect_in[p] || crc_error_reset_in) begin
        des_error_q[p] <= 1'b0;
      end else if (backchannel_crc_err_in[p] && !selftest_active_in[p]) begin
        des_error_q[p] <= 1'b1;
      end
    end

    // Pin-zero configuration. Level and mode are written together by one byte;
    // the revision nibble of the same byte is read-only and is never stored.
    // The drive decode itself lives in the pin module, one per port.
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        pin_zero_local_level_q[p] <= `RAS_RST_LEVEL;
        pin_zero_mode_q[p]        <= `RAS_RST_MODE;
      end else if (bank && hit_wr(reg_req_in, `RAS_OFF_PIN_ZERO)) begin
        pin_zero_local_level_q[p] <= reg_req_in.wdata[`RAS_PZ_LEVEL];
        pin_zero_mode_q[p]        <= reg_req_in.wdata[`RAS_PZ_MODE_MSB:0];
      end
    end

    // The pin flop adds one cycle, so a new setup shows on the pin two edges
    // after the write strobe.
    ras_pin_zero u_pin_zero (
      .core_clk_in     (core_clk_in),
      .sys_rst_in      (sys_rst_in),
      .mode_in         (pin_zero_mode_q[p]),
      .local_level_in  (pin_zero_local_level_q[p]),
      .remote_level_in (remote_level_in[p]),
      .link_up_in      (link_detect_in[p]),
      .drive_out       (pin_zero_out[p])
    );
  end

  // ========================================================================
  // Pixel clock detect
  // The flag only falls on an explicit out-of-range report: a clock that
  // simply stops leaves no report, so the last valid state persists.
  // When both reports arrive together the valid report wins, so a monitor
  // that glitches between the two cannot hide a running clock.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pclk_detect_q <= 1'b0;
    end else if (pclk_valid_in) begin
      pclk_detect_q <= 1'b1;
    end else if (pclk_out_of_range_in) begin
      pclk_detect_q <= 1'b0;
    end
  end

  // ========================================================================
  // Read mux
  // The bank is chosen by the select level in the cycle of the read strobe.
  // The link bit shows the live input rather than a stored copy, so a read
  // always reports the state of the cable at that moment.
  // Unmapped offsets and reserved bits read as zero.
  always_comb begin
    logic p;
    p       = sel;
    rdata_d = `RAS_RST_RDATA;
    case (reg_req_in.addr)
      `RAS_OFF_TARGET_REAL: begin
        rdata_d[`RAS_ADDR_MSB:`RAS_ADDR_LSB] = target_real_address_q[p];
      end
      `RAS_OFF_TARGET_ALIAS: begin
        rdata_d[`RAS_ADDR_MSB:`RAS_ADDR_LSB] = target_alias_address_q[p];
      end
      `RAS_OFF_CRC_LOW: begin
        rdata_d = crc_count_q[p][7:0];
      end
      `RAS_OFF_CRC_HIGH: begin
        rdata_d = crc_count_q[p][15:8];
      end
      `RAS_OFF_HEALTH: begin
        rdata_d[`RAS_HLT_SELFTEST] = selftest_checksum_error_q[p];
        rdata_d[`RAS_HLT_PCLK]     = pclk_detect_q;
        rdata_d[`RAS_HLT_DES_ERR]  = des_error_q[p];
        rdata_d[`RAS_HLT_LINK]     = link_detect_in[p];
      end
      `RAS_OFF_PIN_ZERO: begin
        rdata_d[7:`RAS_PZ_REV_LSB]    = SILICON_REV;
        rdata_d[`RAS_PZ_LEVEL]        = pin_zero_local_level_q[p];
        rdata_d[`RAS_PZ_MODE_MSB:0]   = pin_zero_mode_q[p];
      end
      default: begin
        rdata_d = `RAS_RST_RDATA;
      end
    endcase
  end

  // Read data is captured on a read strobe and then held until the next one.
  // A write in the same cycle as a read lands after it, so the read returns
  // the old value.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= `RAS_RST_RDATA;
    end else if (reg_req_in.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // ========================================================================
  // Alias lookup for forwarded transactions
  // The answer is registered, so it stands for exactly one cycle after the
  // request. An entry with either address at zero never matches, which also
  // keeps a cleared alias from catching transactions to address zero.
  always_comb begin
    fwd_ans_d       = '0;
    fwd_ans_d.valid = fwd_req_in.valid;
    if (fwd_req_in.valid
        && entry_live(target_real_address_q[fwd_req_in.port],
                      target_alias_address_q[fwd_req_in.port])
        && fwd_req_in.addr == target_alias_address_q[fwd_req_in.port]) begin
      fwd_ans_d.hit  = 1'b1;
      fwd_ans_d.addr = target_real_address_q[fwd_req_in.port];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      fwd_ans_q <= '0;
    end else begin
      fwd_ans_q <= fwd_ans_d;
    end
  end

  // ========================================================================
  // Spare request output
  // The spare output carries nothing yet; it comes from a flop held at zero
  // so that every output of the slice is registered.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      unused_q <= '0;
    end else begin
      unused_q <= '0;
    end
  end

  // ========================================================================
  // Outputs
  assign fwd_ans_out    = fwd_ans_q;
  assign reg_rdata_out  = rdata_q;
  assign reg_unused_out = unused_q;

endmodule

// file: tb/ras_far_end.sv
/* Model of the far end: cable link, back-channel errors, self-test and
   the remote pin level. Assumes the bench calls its tasks. */
`timescale 1ns/1ns
module ras_far_end (
  // Clock
  input  wire logic  core_clk_in,
  // Per-port link lines
  output logic [1:0] link_out,
  output logic [1:0] crc_err_out,
  output logic [1:0] selftest_out,
  output logic [1:0] restart_out,
  output logic [1:0] remote_out
);
  initial begin
    link_out = 2'h0;
    crc_err_out = 2'h0;
    selftest_out = 2'h0;
    restart_out = 2'h0;
    remote_out <= 2'h0;
  end

  // ==========================================================================
  // A dead link carries no level, so it toggles to expose a pin that follows it.
  always @(negedge core_clk_in) begin
    foreach (link_out[i]) if (!link_out[i]) remote_out[i] <= ~remote_out[i];
  end

  task automatic errs(input int p, input int n, input logic st);
    selftest_out[p] = st;
    repeat (n) begin
      @(negedge core_clk_in);
      crc_err_out[p] = 1'b1;
      @(negedge core_clk_in);
      crc_err_out[p] = 1'b0;
    end
  endtask
  task automatic restart(input int p);
    @(negedge core_clk_in);
    restart_out[p] = 1'b1;
    @(negedge core_clk_in);
    restart_out[p] = 1'b0;
  endtask
  task automatic set_link(input int p, input logic v);
    @(negedge core_clk_in);
    link_out[p] = v;
  endtask
  task automatic set_remote(input int p, input logic v);
    @(negedge core_clk_in);
    remote_out[p] <= v;
  endtask
endmodule

// file: tb/ras_regs_asserts.sv
/* Port checker of the remote alias, status and pin-zero register slice.
   Assumes it is bound to ras_regs, with the same parameters. */
`timescale 1ns/1ns
module ras_regs_asserts #(
  parameter int         PORTS       = 2,
  parameter logic [3:0] SILICON_REV = 4'h1
) (
  // Clock and reset
  input wire logic                               core_clk_in,
  input wire logic                               sys_rst_in,
  // Register port and controls
  input wire ras_pkg::ras_reg_req_t              reg_req_in,
  input wire logic [7:0]                         reg_rdata_out,
  input wire logic                               second_port_select_in,
  input wire logic                               crc_error_reset_in,
  input wire logic [PORTS-1:0]                   link_detect_in,
  // Lookup and pins
  input wire ras_pkg::ras_fwd_req_t              fwd_req_in,
  input wire ras_pkg::ras_fwd_ans_t              fwd_ans_out,
  input wire ras_pkg::ras_pin_drive_t [PORTS-1:0] pin_zero_out
);
  logic link_sel_q;
  wire logic rd_c = reg_req_in.rd && reg_req_in.addr == 8'h0C;

  // ==========================================================================
  // Helpers
  always_ff @(posedge core_clk_in) begin
    link_sel_q <= link_detect_in[second_port_select_in];
  end

  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // ==========================================================================
  // Properties
  property p_rst_clear;
    disable iff (1'b0)
    sys_rst_in |=> reg_rdata_out == 8'h00 && fwd_ans_out == '0 && pin_zero_out == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear in reset");
  property p_rd_stands;
    !reg_req_in.rd |=> $stable(reg_rdata_out);
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data moved");
  property p_link_live;
    rd_c |=> reg_rdata_out[0] == link_sel_q;
  endproperty
  a_link_live: assert property (p_link_live) else $error("link bit wrong");
  property p_hlt_rsvd;
    rd_c |=> reg_rdata_out[7:4] == 4'h0;
  endproperty
  a_hlt_rsvd: assert property (p_hlt_rsvd) else $error("status upper bits set");
  property p_addr_rsvd;
    reg_req_in.rd && reg_req_in.addr inside {8'h07, 8'h08} |=> !reg_rdata_out[0];
  endproperty
  a_addr_rsvd: assert property (p_addr_rsvd) else $error("address bit 0 set");
  property p_unmapped;
    reg_req_in.rd && !(reg_req_in.addr inside {[8'h07:8'h08], [8'h0A:8'h0D]})
      |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rev;
    reg_req_in.rd && reg_req_in.addr == 8'h0D |=> reg_rdata_out[7:4] == SILICON_REV;
  endproperty
  a_rev: assert property (p_rev) else $error("revision field wrong");
  property p_crc_clear;
    crc_error_reset_in ##1 (crc_error_reset_in && reg_req_in.rd
      && reg_req_in.addr inside {8'h0A, 8'h0B}) |=> reg_rdata_out == 8'h00;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("count not held clear");
  property p_fwd_lat;
    1'b1 |=> fwd_ans_out.valid == $past(fwd_req_in.valid);
  endproperty
  a_fwd_lat: assert property (p_fwd_lat) else $error("lookup answer timing");
  property p_hit_addr;
    fwd_ans_out.hit |-> fwd_ans_out.valid && fwd_ans_out.addr != 7'h00;
  endproperty
  a_hit_addr: assert property (p_hit_addr) else $error("hit with zero address");
  property p_func_quiet;
    pin_zero_out[0].func_sel |-> !pin_zero_out[0].oe;
  endproperty
  a_func_quiet: assert property (p_func_quiet) else $error("pin driven in input mode");

  c_hit: cover property (fwd_ans_out.hit);
  c_pin_oe: cover property (pin_zero_out[0].oe);
  c_selftest: cover property (rd_c ##1 reg_rdata_out[3]);
endmodule

// file: tb/ras_regs_tb.sv
/* Self-checking bench of the register slice with the far-end model.
   Assumes the package, design, model and checker are compiled first. */
`timescale 1ns/1ns
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module ras_regs_tb;
  localparam logic [3:0] REV = 4'h6; // Arbitrary value.
  logic                          clk;
  logic                          rst;
  logic                          sel;
  logic                          crc_rst;
  logic                          pv;
  logic                          poor;
  logic [7:0]                    rdata;
  logic [1:0]                    link, err, st, rs, rl;
  ras_pkg::ras_reg_req_t         req;
  ras_pkg::ras_fwd_req_t         fwd;
  ras_pkg::ras_fwd_ans_t         ans;
  ras_pkg::ras_pin_drive_t [1:0] pin;
  int                            mismatches;
  int                            cmp_count;
  logic [23:0]                   rows [8];

  ras_regs #(.PORTS(2), .SILICON_REV(REV)) i_ras_regs (
    .core_clk_in(clk), .sys_rst_in(rst), .reg_req_in(req), .reg_unused_out(),
    .reg_rdata_out(rdata), .second_port_select_in(sel), .crc_error_reset_in(crc_rst),
    .link_detect_in(link), .backchannel_crc_err_in(err), .selftest_active_in(st),
    .selftest_restart_in(rs), .remote_level_in(rl), .pclk_valid_in(pv),
    .pclk_out_of_range_in(poor), .fwd_req_in(fwd), .fwd_ans_out(ans), .pin_zero_out(pin));
  ras_far_end i_ras_far_end (.core_clk_in(clk), .link_out(link), .crc_err_out(err),
    .selftest_out(st), .restart_out(rs), .remote_out(rl));

  // ==========================================================================
  // Tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = {1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    req = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req = '0;
    `CHK(rdata, e)
  endtask
  task automatic pz(input logic [7:0] d, input int p, input logic [2:0] e);
    wr(8'h0D, d);
    repeat (2) @(negedge clk);
    `CHK(pin[p], e)
  endtask
  task automatic look(input logic p, input logic [6:0] a, input logic h, input logic [6:0] e);
    @(negedge clk);
    fwd = {1'b1, p, a};
    @(negedge clk);
    fwd = '0;
    `CHK({ans.valid, ans.hit}, {1'b1, h})
    if (h) `CHK(ans.addr, e)
  endtask
  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Sequence
  initial begin
    {rst, sel, crc_rst, pv, poor} = 5'h10;
    req = '0;
    fwd = '0;
    mismatches = 0;
    cmp_count = 0;
    rows = '{24'h07FFFE, 24'h08A5A4, {8'h0D, 8'hFB, REV, 4'hB}, 24'h0AFF00, 24'h0BFF00,
             24'h0CFF00, 24'h09FF00, 24'h070000};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    wr(8'h07, 8'h54);
    wr(8'h08, 8'h66);
    look(1'b0, 7'h33, 1'b1, 7'h2A);
    look(1'b0, 7'h2A, 1'b0, 7'h00);
    look(1'b1, 7'h33, 1'b0, 7'h00);
    sel = 1'b1;
    rd(8'h08, 8'h00);
    wr(8'h07, 8'h54);
    look(1'b1, 7'h33, 1'b0, 7'h00);
    sel = 1'b0;
    wr(8'h07, 8'h00);
    look(1'b0, 7'h33, 1'b0, 7'h00);
    i_ras_far_end.set_link(0, 1'b1);
    i_ras_far_end.errs(0, 260, 1'b0);
    rd(8'h0A, 8'h04);
    rd(8'h0B, 8'h01);
    rd(8'h0C, 8'h03);
    i_ras_far_end.errs(0, 1, 1'b1);
    rd(8'h0C, 8'h0B);
    i_ras_far_end.restart(0);
    rd(8'h0C, 8'h03);
    sel = 1'b1;
    rd(8'h0A, 8'h00);
    sel = 1'b0;
    crc_rst = 1'b1;
    i_ras_far_end.errs(0, 1, 1'b1);
    rd(8'h0A, 8'h00);
    rd(8'h0C, 8'h01);
    crc_rst = 1'b0;
    i_ras_far_end.errs(0, 1, 1'b0);
    rd(8'h0A, 8'h01);
    i_ras_far_end.set_link(0, 1'b0);
    rd(8'h0C, 8'h00);
    pv = 1'b1;
    @(negedge clk);
    pv = 1'b0;
    rd(8'h0C, 8'h04);
    poor = 1'b1;
    @(negedge clk);
    poor = 1'b0;
    rd(8'h0C, 8'h00);
    i_ras_far_end.set_link(0, 1'b1);
    i_ras_far_end.set_remote(0, 1'b1);
    pz(8'h09, 0, 3'b110);
    pz(8'h01, 0, 3'b010);
    pz(8'h0C, 0, 3'b001);
    pz(8'h0A, 0, 3'b000);
    pz(8'h0B, 0, 3'b000);
    pz(8'h0E, 0, 3'b000);
    pz(8'h08, 0, 3'b001);
    pz(8'h05, 0, 3'b110);
    i_ras_far_end.set_link(0, 1'b0);
    repeat (5) @(negedge clk);
    `CHK(pin[0], 3'b110)
    i_ras_far_end.set_link(0, 1'b1);
    i_ras_far_end.set_remote(0, 1'b0);
    pz(8'h0F, 0, 3'b010);
    i_ras_far_end.set_link(0, 1'b0);
    repeat (3) @(negedge clk);
    `CHK(pin[0], 3'b110)
    sel = 1'b1;
    pz(8'h09, 1, 3'b110);
    `CHK(pin[0], 3'b110)
    rst = 1'b1;
    repeat (20) @(negedge clk);
    `CHK(pin, 6'h00)
    rst = 1'b0;
    sel = 1'b0;
    for (int a = 7; a < 14; a++) rd(8'(a), a == 13 ? {REV, 4'h0} : 8'h00);
    finish_test();
  end
endmodule

bind ras_regs ras_regs_asserts #(.PORTS(PORTS), .SILICON_REV(SILICON_REV)) i_ras_regs_asserts (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .second_port_select_in(second_port_select_in),
  .crc_error_reset_in(crc_error_reset_in), .link_detect_in(link_detect_in),
  .fwd_req_in(fwd_req_in), .fwd_ans_out(fwd_ans_out), .pin_zero_out(pin_zero_out));
